// >>> hw/ssam_cfg.svh
// Constants for the serial converter control block: timing counts and field positions.
`ifndef SSAM_CFG_SVH
`define SSAM_CFG_SVH
`define SSAM_CLK_MHZ          100
`define SSAM_HOLD_OFF_NS      1000
`define SSAM_HOLD_OFF_CYC     ((`SSAM_HOLD_OFF_NS * `SSAM_CLK_MHZ + 999) / 1000)
`define SSAM_RESULT_BITS      8
`define SSAM_FIFO_DEPTH       16
`define SSAM_ADDR_SGL_BIT     3
`define SSAM_ADDR_POL_BIT     2
`define SSAM_ADDR_SEL1_BIT    1
`define SSAM_ADDR_SEL0_BIT    0
`endif

// >>> hw/ssam_pkg.sv
// Types for the serial converter control block.
package ssam_pkg;
  // Serial sequence phases, one-hot.
  typedef enum logic [6:0] {
    SSAM_IDLE   = 7'h01,
    SSAM_ADDR   = 7'h02,
    SSAM_SAMPLE = 7'h04,
    SSAM_CONV   = 7'h08,
    SSAM_LSB    = 7'h10,
    SSAM_HOLD   = 7'h20,
    SSAM_LOW    = 7'h40
  } ssam_state_t;
endpackage

// >>> hw/ssam_fifo.sv
// Small synchronous FIFO that buffers finished conversion results.
module ssam_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  // Refuse depths that the wrapping pointers cannot serve, at elaboration.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];   // Storage array.
  logic [AW:0]      wr_r;            // Write pointer with wrap bit.
  logic [AW:0]      rd_r;            // Read pointer with wrap bit.
  wire              full  = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  wire              empty = (wr_r == rd_r);
  wire              push  = i_valid && !full;
  wire              pop   = i_ready && !empty;
  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data  = mem_r[rd_r[AW-1:0]];
  // Pointers move on accepted transfers only, so a stalled reader fills the queue.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop)  rd_r <= rd_r + 1'b1;
    end
  end
  // Storage write needs no reset.
  always_ff @(posedge i_clock) begin
    if (push) mem_r[wr_r[AW-1:0]] <= i_data;
  end
endmodule

// >>> hw/ssam_top.sv
// Control and serial interface of an 8-bit successive approximation converter with input multiplexer.
`include "ssam_cfg.svh"
// Overview of operation
// - Falling select starts sequence, awaiting start bit.
// - Each rising clock shifts serial_in into address.
// - First one is start bit; zeros ignored.
// - Address word of 3 or 4 bits follows.
// - Half clock sampling interval after the address word.
// - Raise conversion_active, then ignore serial_in.
// - Output leaves high impedance with leading zero.
// - Bit is one when input exceeds trial.
// - Results driven on falling edge, MSB first.
// - Eight periods; active drops half cycle later.
// - Approximation register copied into output shifter.
// - Shift enable high holds LSB; low shifts.
// - Without shift enable, LSB stream follows automatically.
// - After bits, output low until select rises.
// - Single channel variant: MSB only, hold last.
// - Registers clear after select high hold-off time.
// - Input sampled only while output high impedance.
// - Eight channel pair mode: pair and polarity.
// - Four channel variant: one select plus polarity.
// - Each conversion may use a new configuration.
// - Result is an 8-bit code of 256.
// - Eight channel single mode uses shared minus.
// - Positive below negative gives all zeros.
module ssam_top
  import ssam_pkg::*;
#(
  parameter int CHANNELS   = 8,                    // 1, 4 or 8 analog channels.
  parameter bit HAS_SHIFT_EN = 1'b1,               // Shift enable input present.
  parameter int HOLD_OFF_CYC = `SSAM_HOLD_OFF_CYC  // Select hold-off in system clocks.
) (
  input  wire logic       i_clock,            // System clock, 100 MHz.
  input  wire logic       i_rst_n,            // Synchronous reset, active low.
  input  wire logic       i_select_n,         // Chip select from host, active low.
  input  wire logic       i_serial_clk,       // Serial clock level from host, sampled.
  input  wire logic       i_serial_in,        // Serial address input.
  input  wire logic       i_lsb_shift_enable, // Holds LSB while high.
  input  wire logic       i_compare,          // Comparator: input above trial level.
  input  wire logic       i_below_negative,   // Positive input below negative input.
  output logic [7:0]      o_trial_code,       // Trial code for the internal divider.
  output logic [7:0]      o_channel_pos,      // One-hot positive input select.
  output logic [8:0]      o_channel_neg,      // One-hot negative select, bit 8 is the shared minus.
  output logic            o_sample,           // Track/hold sampling strobe.
  output logic            o_conversion_active,// Conversion in progress.
  output logic            o_serial_out,       // Serial output data.
  output logic            o_serial_out_en,    // Serial output enable.
  output logic            o_result_valid,     // Buffered result available.
  input  wire logic       i_result_ready,     // Buffered result taken.
  output logic [7:0]      o_result            // Buffered result.
);
  localparam int ABITS = (CHANNELS == 8) ? 4 : (CHANNELS == 4) ? 3 : 0;  // Address word length.
  // Refuse configurations the sequencer cannot serve, at elaboration.
  if (CHANNELS != 1 && CHANNELS != 4 && CHANNELS != 8) begin : g_bad_channels
    $error("CHANNELS must be 1, 4 or 8");
  end
  if (HOLD_OFF_CYC < 1) begin : g_bad_hold_off
    $error("HOLD_OFF_CYC must be at least one");
  end

  ssam_state_t state_r;        // Sequence phase.
  ssam_state_t state_nxt;      // Next phase.
  logic        sclk_r;         // Serial clock seen last cycle.
  logic [3:0]  addr_r;         // Address shift register.
  logic [2:0]  addr_cnt_r;     // Address bits still expected.
  logic [7:0]  sar_r;          // Approximation register.
  logic [7:0]  shift_r;        // LSB-first output shifter.
  logic [3:0]  bit_cnt_r;      // Comparison or output bit counter.
  logic        out_r;          // Serial output data flop.
  logic        out_en_r;       // Serial output enable flop.
  logic        active_r;       // Conversion active flop.
  logic        neg_r;          // Negative-over-positive latched at sampling.
  logic [31:0] hold_cnt_r;     // Select-high hold-off counter.
  logic        push_r;         // One-cycle push of a finished result.
  logic [7:0]  pos_r;          // Positive channel select.
  logic [8:0]  negsel_r;       // Negative channel select.

  // Edge detection on the sampled serial clock; inputs are synchronous already.
  wire rise    = i_serial_clk && !sclk_r;
  wire fall    = !i_serial_clk && sclk_r;
  wire sel_on  = !i_select_n;
  wire cleared = (hold_cnt_r >= HOLD_OFF_CYC);
  wire [7:0] trial_bit = 8'h80 >> bit_cnt_r[2:0];
  wire [7:0] sar_keep  = neg_r ? 8'h00 : (sar_r | (i_compare ? trial_bit : 8'h00));
  // Address decode for the channel selects.
  wire       a_sgl = addr_r[`SSAM_ADDR_SGL_BIT];
  wire       a_pol = addr_r[`SSAM_ADDR_POL_BIT];
  wire [1:0] a_sel = {addr_r[`SSAM_ADDR_SEL1_BIT], addr_r[`SSAM_ADDR_SEL0_BIT]};
  wire [2:0] ch8   = {a_sel, a_pol};                      // 2*select+polarity
  wire [2:0] pr8   = {a_sel, !a_pol};                     // Partner of the pair.
  wire [2:0] ch4   = {1'b0, addr_r[0], addr_r[1]};        // Four-channel: 2*select+polarity
  wire [2:0] pr4   = {1'b0, addr_r[0], !addr_r[1]};       // Partner of the four-channel pair.
  wire       s4    = addr_r[2];
  wire [2:0] p_idx = (CHANNELS == 8) ? ch8 : (CHANNELS == 4) ? ch4 : 3'h0;
  wire [2:0] n_idx = (CHANNELS == 8) ? pr8 : (CHANNELS == 4) ? pr4 : 3'h1;
  wire       to_common = (CHANNELS == 8) ? a_sgl : (CHANNELS == 4) ? s4 : 1'b0;

  // Phase sequencing.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SSAM_IDLE: begin
        if (sel_on) state_nxt = SSAM_ADDR;
      end
      SSAM_ADDR: begin
        if (rise && (addr_cnt_r == 3'h0) && (i_serial_in || (ABITS == 0))) begin
          state_nxt = (ABITS == 0) ? SSAM_SAMPLE : SSAM_ADDR;
        end
        if (rise && (addr_cnt_r == 3'h1)) state_nxt = SSAM_SAMPLE;
      end
      SSAM_SAMPLE: begin
        if (fall) state_nxt = SSAM_CONV;
      end
      SSAM_CONV: begin
        if (fall && bit_cnt_r == 4'd8) begin
          if (CHANNELS == 1) state_nxt = SSAM_HOLD;
          else               state_nxt = SSAM_LSB;
        end
      end
      SSAM_LSB: begin
        if (fall && bit_cnt_r == 4'd7 && !(HAS_SHIFT_EN && i_lsb_shift_enable)) state_nxt = SSAM_LOW;
      end
      SSAM_HOLD, SSAM_LOW: state_nxt = state_r;
      default: state_nxt = SSAM_IDLE;
    endcase
    if (!sel_on) state_nxt = SSAM_IDLE;
  end

  // Phase register and serial clock history.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_r <= SSAM_IDLE;
      sclk_r  <= 1'b1;  // Idle clock level is high, so no false rise follows reset.
    end else begin
      state_r <= state_nxt;
      sclk_r  <= i_serial_clk;
    end
  end

  // Select-high hold-off timer; counts only while select is high, and saturates.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || sel_on) hold_cnt_r <= '0;
    else if (!cleared)      hold_cnt_r <= hold_cnt_r + 32'd1;
  end

  // Address capture: input is looked at only in the address phase.
  // A start bit that arrives before hold-off elapses still counts, since the host owns that timing.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || (!sel_on && cleared)) begin
      addr_r     <= 4'h0;
      addr_cnt_r <= 3'h0;
    end else if (state_r == SSAM_ADDR && rise) begin
      if (addr_cnt_r == 3'h0) begin
        if (i_serial_in) addr_cnt_r <= 3'(ABITS);          // Start bit found.
      end else begin
        addr_r     <= {addr_r[2:0], i_serial_in};
        addr_cnt_r <= addr_cnt_r - 3'h1;
      end
    end else if (state_r == SSAM_IDLE) begin
      addr_cnt_r <= 3'h0;
    end
  end

  // Channel selects are latched at sampling so each conversion uses its own word.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || (!sel_on && cleared)) begin
      pos_r    <= 8'h00;
      negsel_r <= 9'h000;
      neg_r    <= 1'b0;
    end else if (state_r == SSAM_SAMPLE && fall) begin
      pos_r    <= 8'h01 << p_idx;
      negsel_r <= to_common ? 9'h100 : (9'h001 << n_idx);
      neg_r    <= i_below_negative;
    end
  end

  // Comparison and output shifting, all on serial clock falling edges.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || (!sel_on && cleared)) begin
      sar_r     <= 8'h00;
      shift_r   <= 8'h00;
      bit_cnt_r <= 4'h0;
      out_r     <= 1'b0;
      push_r    <= 1'b0;
    end else begin
      push_r <= 1'b0;
      if (fall) begin
        case (state_r)
          SSAM_SAMPLE: begin
            out_r     <= 1'b0;                              // Leading zero
            bit_cnt_r <= 4'h0;
            sar_r     <= 8'h00;
          end
          SSAM_CONV: begin
            if (bit_cnt_r < 4'd8) begin
              sar_r     <= sar_keep;
              out_r     <= !neg_r && i_compare;
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else begin
              shift_r   <= sar_r;
              push_r    <= 1'b1;
              bit_cnt_r <= 4'h0;
              out_r     <= sar_r[0];                        // LSB is the last MSB bit too.
            end
          end
          SSAM_LSB: begin
            if (!(HAS_SHIFT_EN && i_lsb_shift_enable)) begin
              shift_r   <= {1'b0, shift_r[7:1]};
              out_r     <= shift_r[1];
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
          SSAM_LOW: out_r <= 1'b0;
          default: out_r <= out_r;                          // Hold keeps last bit
        endcase
      end
    end
  end

  // Output enable and conversion-active flag; active falls half a period after completion.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !sel_on) begin
      out_en_r <= 1'b0;
      active_r <= 1'b0;
    end else begin
      if (state_r == SSAM_SAMPLE && fall) begin
        out_en_r <= 1'b1;
        active_r <= 1'b1;
      end
      if (state_r == SSAM_CONV && bit_cnt_r == 4'd8 && rise) active_r <= 1'b0;
    end
  end

  // Result queue lets the local side read results at its own pace; a full queue drops nothing
  // on the serial side, it simply refuses the push, which the local reader must avoid.
  ssam_fifo #(
    .WIDTH (`SSAM_RESULT_BITS),
    .DEPTH (`SSAM_FIFO_DEPTH)
  ) u_fifo (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_valid (push_r),
    .o_ready (),
    .i_data  (shift_r),
    .o_valid (o_result_valid),
    .i_ready (i_result_ready),
    .o_data  (o_result)
  );

  assign o_trial_code        = sar_r | trial_bit;
  assign o_channel_pos       = pos_r;
  assign o_channel_neg       = negsel_r;
  assign o_sample            = (state_r == SSAM_SAMPLE);
  assign o_conversion_active = active_r;
  assign o_serial_out        = out_r;
  assign o_serial_out_en     = out_en_r;
endmodule

// >>> test/ssam_top_asserts.sv
// Concurrent checks on the ports of the converter control block.
module ssam_top_chk #(
  parameter int HOLD_OFF_CYC = 4  // Select hold-off in system clocks.
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_select_n,
  input  wire logic       i_serial_clk,
  input  wire logic       i_result_ready,
  input  wire logic [7:0] o_trial_code,
  input  wire logic [7:0] o_channel_pos,
  input  wire logic [8:0] o_channel_neg,
  input  wire logic       o_sample,
  input  wire logic       o_conversion_active,
  input  wire logic       o_serial_out,
  input  wire logic       o_serial_out_en,
  input  wire logic       o_result_valid,
  input  wire logic [7:0] o_result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sel_cnt_r;   // Cycles with select high, saturating.
  logic [4:0] fall_cnt_r;  // Serial falls seen while the output drives.
  logic       sclk_r;      // Serial clock one cycle back.
  // Counters replace long repetitions, which would slow the tools badly.
  always_ff @(posedge i_clock) begin
    sclk_r <= i_serial_clk;
    if (!i_rst_n || !i_select_n) sel_cnt_r <= 8'h00;
    else if (sel_cnt_r != 8'hFF) sel_cnt_r <= sel_cnt_r + 8'h01;
    if (!o_serial_out_en) fall_cnt_r <= 5'h00;
    else if (sclk_r && !i_serial_clk) fall_cnt_r <= fall_cnt_r + 5'h01;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_select_off: assert property (i_select_n |=> !o_serial_out_en && !o_conversion_active)
    else $error("output active while deselected");
  a_lead_zero: assert property (
    $rose(o_serial_out_en) |-> !o_serial_out && $rose(o_conversion_active))
    else $error("output did not start with a zero");
  a_sample_first: assert property (
    $rose(o_conversion_active) |-> $past(o_sample) || $past(o_sample, 2))
    else $error("conversion began without sampling");
  a_sample_quiet: assert property (o_sample |-> !o_serial_out_en)
    else $error("output driven during sampling");
  a_first_trial: assert property ($rose(o_conversion_active) |-> o_trial_code == 8'h80)
    else $error("first trial not mid scale");
  a_fall_edge: assert property (
    $changed(o_serial_out) && o_serial_out_en && $past(o_serial_out_en) |-> !i_serial_clk)
    else $error("data changed while serial clock high");
  a_active_end: assert property (
    $fell(o_conversion_active) |-> fall_cnt_r == 5'h08 && i_serial_clk)
    else $error("conversion end at wrong period");
  a_hold_clear: assert property (
    sel_cnt_r >= HOLD_OFF_CYC + 2 |-> o_channel_pos == 8'h00 && o_channel_neg == 9'h000)
    else $error("selects kept after hold-off");
  a_select_onehot: assert property (
    o_conversion_active |-> $onehot(o_channel_pos) && $onehot(o_channel_neg))
    else $error("input selects not one-hot");
  a_fifo_stall: assert property (o_result_valid && !i_result_ready |=> o_result_valid && $stable(o_result))
    else $error("buffered result moved while stalled");
  c_start: cover property ($rose(o_conversion_active));
  c_end: cover property ($fell(o_conversion_active));
  c_stall: cover property (o_result_valid && !i_result_ready);
endmodule
bind ssam_top ssam_top_chk #(
  .HOLD_OFF_CYC (HOLD_OFF_CYC)
) u_chk (
  .i_clock             (i_clock),
  .i_rst_n             (i_rst_n),
  .i_select_n          (i_select_n),
  .i_serial_clk        (i_serial_clk),
  .i_result_ready      (i_result_ready),
  .o_trial_code        (o_trial_code),
  .o_channel_pos       (o_channel_pos),
  .o_channel_neg       (o_channel_neg),
  .o_sample            (o_sample),
  .o_conversion_active (o_conversion_active),
  .o_serial_out        (o_serial_out),
  .o_serial_out_en     (o_serial_out_en),
  .o_result_valid      (o_result_valid),
  .o_result            (o_result)
);

// >>> test/ssam_host_model.sv
// Host serial port and analog input model facing the converter block.
module ssam_host_model #(
  parameter int HP = 4  // Serial half period in system clocks.
) (
  input  wire logic       i_clock,
  input  wire logic [7:0] i_level,       // Analog input level as a code.
  input  wire logic [7:0] i_trial_code,
  input  wire logic       i_serial_out,
  input  wire logic       i_serial_out_en,
  output logic            o_select_n,
  output logic            o_serial_clk,
  output logic            o_serial_in,
  output logic            o_shift_en,
  output logic            o_compare
);
  timeunit 1ns;
  timeprecision 1ps;
  // The input sits half a step above its code, so it exceeds every lower trial.
  assign o_compare = {i_level, 1'b1} > {i_trial_code, 1'b0};
  // Idle with clock and select both high, which also resets the device.
  initial begin
    o_select_n = 1'b1;
    o_serial_clk = 1'b1;
    o_serial_in = 1'b0;
    o_shift_en = 1'b0;
  end
  // One serial period: data set while low, taken at the rise, then the fall.
  task automatic bit_out(input logic b);
    o_serial_in <= b;
    repeat (HP) @(posedge i_clock);
    o_serial_clk <= 1'b1;
    repeat (HP) @(posedge i_clock);
    o_serial_clk <= 1'b0;
  endtask
  // Whole frame; each output bit is read just before the following rise.
  task automatic frame(input logic [3:0] ad, input int z, input int h, output logic [31:0] got);
    got = '0;
    @(posedge i_clock);
    o_serial_clk <= 1'b0;
    @(posedge i_clock);
    o_select_n <= 1'b0;
    repeat (z) bit_out(1'b0);
    bit_out(1'b1);
    for (int i = 3; i >= 0; i--) bit_out(ad[i]);
    for (int k = 0; k < 18 + h; k++) begin
      // The input line is not released quietly: it toggles to expose misuse.
      o_serial_in <= k[0];
      // Set with fall k; the LSB is loaded at fall 9, and holding covers falls 10 to 9 + h.
      o_shift_en <= k >= 10 && k < 10 + h;
      repeat (HP) @(posedge i_clock);
      got = {got[30:0], i_serial_out_en ? i_serial_out : 1'bz};
      o_serial_clk <= 1'b1;
      repeat (HP) @(posedge i_clock);
      o_serial_clk <= 1'b0;
    end
    @(posedge i_clock);
    o_serial_clk <= 1'b1;
    o_select_n <= 1'b1;
    repeat (3 * HP) @(posedge i_clock);
  endtask
endmodule

// >>> test/tb_ssam_top.sv
// Self-checking bench for the converter control block.
module tb_ssam_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, ready, below;    // Bench-driven inputs.
  logic [7:0]  vin;                         // Analog level for the next frame.
  logic        sel_n, sclk, sin, se, cmp;   // Driven by the host model.
  logic [7:0]  trial, pos, res;
  logic [8:0]  neg;
  logic        act, sout, sen, valid;
  logic [7:0]  q[$];                        // Results expected from the buffer.
  int          err_count = 0;
  int          samples_checked = 0;
  ssam_top #(.CHANNELS(8), .HAS_SHIFT_EN(1'b1), .HOLD_OFF_CYC(4)) dut (
    .i_clock(clk), .i_rst_n(rst_n), .i_select_n(sel_n), .i_serial_clk(sclk),
    .i_serial_in(sin), .i_lsb_shift_enable(se), .i_compare(cmp), .i_below_negative(below),
    .o_trial_code(trial), .o_channel_pos(pos), .o_channel_neg(neg), .o_sample(),
    .o_conversion_active(act), .o_serial_out(sout), .o_serial_out_en(sen),
    .o_result_valid(valid), .i_result_ready(ready), .o_result(res));
  ssam_host_model #(.HP(4)) u_host (
    .i_clock(clk), .i_level(vin), .i_trial_code(trial), .i_serial_out(sout),
    .i_serial_out_en(sen), .o_select_n(sel_n), .o_serial_clk(sclk),
    .o_serial_in(sin), .o_shift_en(se), .o_compare(cmp));
  // Free-running 100 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare, count, and report any difference at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors=%0d checks=%0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Expected selects {neg, pos}; a single-ended input pairs with the shared minus.
  function automatic logic [16:0] chan(input logic [3:0] a);
    int p;
    p = 2 * a[1:0] + a[2];
    return {a[3] ? 9'h100 : 9'h001 << (p ^ 1), 8'h01 << p};
  endfunction
  // Expected line: zero, MSB first, LSB repeated while held, LSB first, then low.
  function automatic logic [31:0] seq(input logic [7:0] r, input int h);
    logic [31:0] s;
    s = '0;
    for (int k = 0; k < 18 + h; k++) begin
      s = {s[30:0], k == 0 ? 1'b0 : k <= 8 ? r[8 - k] : k <= 9 + h ? r[0] :
           k <= 16 + h ? r[k - 9 - h] : 1'b0};
    end
    return s;
  endfunction
  // One conversion with selects checked once the conversion is under way.
  task automatic run(input logic [3:0] ad, input logic [7:0] v, input int z, input int h, input logic bn);
    logic [31:0] got;
    logic [7:0]  r;
    r = bn ? 8'h00 : v;
    vin <= v;
    below <= bn;
    fork
      u_host.frame(ad, z, h, got);
      begin
        for (int i = 0; i < 400 && !act; i++) @(posedge clk);
        chk({15'h0000, neg, pos}, {15'h0000, chan(ad)});
      end
    join
    chk(got, seq(r, h));
    if (q.size() < 16) q.push_back(r);
  endtask
  // Hang guard, well beyond seventeen frames and a drain.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test();
  end
  initial begin
    rst_n = 1'b0;
    ready = 1'b0;
    below = 1'b0;
    vin = 8'h00;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Addresses 0 to 15 with the reader stalled, then address 0 again; the last frame overflows.
    for (int a = 0; a < 17; a++) begin
      run(a[3:0], a == 16 ? 8'hA5 : 8'(a * 17), a % 3, a == 5 ? 3 : 0, a == 7);
    end
    @(posedge clk);
    chk(valid, 1'b1);
    ready <= 1'b1;
    foreach (q[i]) begin
      @(posedge clk);
      chk(valid, 1'b1);
      chk(res, q[i]);
    end
    ready <= 1'b0;
    @(posedge clk);
    chk(valid, 1'b0);
    stop_test();
  end
endmodule
